// File: verilog/dcrb_cfg.svh
/*
 Constants of the device configuration register bank: register
 indices, field positions, reset values and codes.
 Assumes inclusion by bare name from every design file that needs it.
*/
// ----------------------------------------------------------------
// Operation
// R1 - On fault the speed-pulse output toggles, floats or goes low per two-bit code.
// R2 - Fifteen-bit field holds maximum frequency-input speed command in hertz.
// R3 - Spread-spectrum bit is inverted: zero enables, one disables.
// R4 - Idle select bit: zero picks standby, one picks sleep.
// R5 - Duty band bit: zero accepts 325 Hz-100 kHz, one accepts 10-325 Hz.
// R6 - Clock source field: code 0 internal oscillator, code 3 external clock.
// R7 - One bit enables use of the outside reference clock input.
// R8 - Outside reference rate doubles per code from 8 kHz to 1024 kHz.
// R9 - Device configuration word resets to all zeros.
// R10 - Gate-driver words reset to 0x00228000 and 0x01200000.
// R11 - Software leaves unlisted gate-driver offsets unwritten.
// R12 - Speed command source: analog 0, duty 1, frequency 3; ceiling only in frequency.
// R13 - Bit 31 stored as read-write parity; reserved fields read zero after reset.
// ----------------------------------------------------------------
`ifndef DCRB_CFG_SVH
`define DCRB_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DCRB_IDX_PIN_CFG_TWO 8'hA6
`define DCRB_IDX_DEV_CFG 8'hA8
`define DCRB_IDX_GD_CFG_ONE 8'hAC
`define DCRB_IDX_GD_CFG_TWO 8'hAE
`define DCRB_IDX_STATUS 8'hB0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DCRB_RST_PIN_CFG_TWO 32'h0000_0000
`define DCRB_RST_DEV_CFG 32'h0000_0000
`define DCRB_RST_GD_CFG_ONE 32'h0022_8000
`define DCRB_RST_GD_CFG_TWO 32'h0120_0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DCRB_FLT_HI 12
`define DCRB_FLT_LO 11
`define DCRB_MAXF_HI 30
`define DCRB_MAXF_LO 16
`define DCRB_SSM_BIT 14
`define DCRB_IDLE_BIT 11
`define DCRB_BAND_BIT 10
`define DCRB_CLK_HI 9
`define DCRB_CLK_LO 8
`define DCRB_EXTEN_BIT 6
`define DCRB_RATE_HI 5
`define DCRB_RATE_LO 3
`define DCRB_STAT_FLAGS_LO 16

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define DCRB_FLT_TOGGLE 2'h0
`define DCRB_FLT_FLOAT 2'h1
`define DCRB_FLT_LOW 2'h2
`define DCRB_CLK_EXT 2'h3
`define DCRB_SRC_FREQ 2'h3
`define DCRB_RATE_BASE_KHZ 11'h008
`define DCRB_SLOT_NONE 3'h7
`define DCRB_SLOT_STATUS 3'h4

`endif

// File: verilog/dcrb_pkg.sv
/*
 Types shared by the configuration register bank modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dcrb_pkg;

    typedef logic [31:0] dcrb_word_type;

    typedef enum logic [2:0] {
        PULSE_RUN,
        PULSE_TOGGLE,
        PULSE_HALTED,
        PULSE_FLOAT,
        PULSE_LOW
    } dcrb_pulse_state_type;

endpackage

// File: verilog/dcrb_sync2.sv
/*
 Two-stage synchroniser with rising-edge pulse for one pin.
 Assumes the pin is asynchronous to core_clk.
*/
`timescale 1ns/1ps
module dcrb_sync2 import dcrb_pkg::*; (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic pinIn,
    output logic levelOut,
    output logic risePulse
);

    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    // Only the second stage and the edge stage are ever looked at
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= pinIn;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign levelOut = sync_ff;
    assign risePulse = sync_ff & ~last_ff;

endmodule

// File: verilog/dcrb_pulse_out.sv
/*
 Speed-pulse output driver with selectable behaviour during a fault.
 Assumes fault, halt and raw pulse come from logic on core_clk.
*/
`timescale 1ns/1ps
`include "dcrb_cfg.svh"
module dcrb_pulse_out import dcrb_pkg::*; (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic faultActive,
    input wire logic motorHalted,
    input wire logic pulseIn,
    input wire logic [1:0] faultBehaviour,
    output logic pulseOut,
    output logic pulseOe
);

    dcrb_pulse_state_type state_ff;
    dcrb_pulse_state_type nxt_state;
    logic out_ff;
    logic nxt_out;
    logic oe_ff;
    logic nxt_oe;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            PULSE_RUN: begin
                if (faultActive) begin
                    case (faultBehaviour)
                        `DCRB_FLT_FLOAT: nxt_state = PULSE_FLOAT; // see R1
                        `DCRB_FLT_LOW: nxt_state = PULSE_LOW; // see R1
                        // Reserved code falls back to toggling
                        default: nxt_state = PULSE_TOGGLE; // see R1
                    endcase
                end
            end
            PULSE_TOGGLE: begin
                if (!faultActive) begin
                    nxt_state = PULSE_RUN;
                end else if (motorHalted) begin
                    nxt_state = PULSE_HALTED;
                end
            end
            PULSE_HALTED, PULSE_FLOAT, PULSE_LOW: begin
                if (!faultActive) begin
                    nxt_state = PULSE_RUN;
                end
            end
            default: nxt_state = PULSE_RUN;
        endcase
    end

    always_comb begin
        nxt_out = out_ff;
        nxt_oe = 1'b1;
        case (nxt_state)
            PULSE_RUN, PULSE_TOGGLE: nxt_out = pulseIn; // see R1
            // Holds the last level once the rotor stops
            PULSE_HALTED: nxt_out = out_ff; // see R1
            PULSE_FLOAT: begin
                nxt_out = 1'b0;
                nxt_oe = 1'b0; // see R1
            end
            PULSE_LOW: nxt_out = 1'b0; // see R1
            default: nxt_out = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= PULSE_RUN;
            out_ff <= 1'b0;
            oe_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
        end
    end

    assign pulseOut = out_ff;
    assign pulseOe = oe_ff;

endmodule

// File: verilog/dcrb_regbank.sv
/*
 Device configuration register bank on an APB slave port.
 Holds the pin, device and gate-driver configuration words, decodes
 the device word into clocking, idle and speed-input settings, and
 drives the speed-pulse output through its fault behaviour.
 Assumes an APB master on core_clk; motor fault, halt, raw pulse and
 speed command source come from logic on core_clk; the outside
 reference clock arrives on an asynchronous pin.
*/
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "dcrb_cfg.svh"
module dcrb_regbank import dcrb_pkg::*; #(
    parameter int ADDR_W = 12,
    parameter int EDGE_CNT_W = 16
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic motorFault,
    input wire logic motorHalted,
    input wire logic rawSpeedPulse,
    input wire logic [1:0] speedCommandSource,
    input wire logic outsideRefPin,
    output logic speedPulseOut,
    output logic speedPulseOe,
    output logic [14:0] freqCeilingHz,
    output logic freqCeilingActive,
    output logic spreadSpectrumOn,
    output logic idleSleepSelect,
    output logic dutyInputBandLow,
    output logic useOutsideReference,
    output logic [10:0] outsideReferenceKhz,
    output logic outsideReferenceTick,
    output logic [31:0] gateDriverOneWord,
    output logic [31:0] gateDriverTwoWord
);

    localparam int NUM_CFG = 4;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic [ADDR_W-1:0] byteAddr(input logic [7:0] idx);
        byteAddr = ADDR_W'({idx, 2'b00});
    endfunction

    // Slots 0..3 are configuration words, 4 is status
    function automatic logic [2:0] decodeSlot(input logic [ADDR_W-1:0] addr);
        decodeSlot = `DCRB_SLOT_NONE;
        if (addr == byteAddr(`DCRB_IDX_PIN_CFG_TWO)) begin
            decodeSlot = 3'h0;
        end else if (addr == byteAddr(`DCRB_IDX_DEV_CFG)) begin
            decodeSlot = 3'h1;
        end else if (addr == byteAddr(`DCRB_IDX_GD_CFG_ONE)) begin
            decodeSlot = 3'h2;
        end else if (addr == byteAddr(`DCRB_IDX_GD_CFG_TWO)) begin
            decodeSlot = 3'h3;
        end else if (addr == byteAddr(`DCRB_IDX_STATUS)) begin
            decodeSlot = `DCRB_SLOT_STATUS;
        end
    endfunction

    function automatic dcrb_word_type resetWord(input int idx);
        case (idx)
            0: resetWord = `DCRB_RST_PIN_CFG_TWO;
            1: resetWord = `DCRB_RST_DEV_CFG; // see R9
            2: resetWord = `DCRB_RST_GD_CFG_ONE; // see R10
            default: resetWord = `DCRB_RST_GD_CFG_TWO; // see R10
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    dcrb_word_type cfgWord_ff [NUM_CFG];
    dcrb_word_type nxt_cfgWord [NUM_CFG];
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;
    logic [2:0] slot;
    logic setupPhase;
    logic writeTaken;
    dcrb_word_type statusWord;
    dcrb_word_type readWord;

    logic [14:0] freqCeiling_ff;
    logic [14:0] nxt_freqCeiling;
    logic freqActive_ff;
    logic nxt_freqActive;
    logic ssmOn_ff;
    logic nxt_ssmOn;
    logic sleepSel_ff;
    logic nxt_sleepSel;
    logic bandLow_ff;
    logic nxt_bandLow;
    logic useRef_ff;
    logic nxt_useRef;
    logic [10:0] refKhz_ff;
    logic [10:0] nxt_refKhz;
    logic refTick_ff;
    logic nxt_refTick;
    logic [EDGE_CNT_W-1:0] refEdgeCnt_ff;
    logic [EDGE_CNT_W-1:0] nxt_refEdgeCnt;

    logic refLevel;
    logic refRise;
    logic pulseOutInt;
    logic pulseOeInt;

    dcrb_word_type devCfg;
    assign devCfg = cfgWord_ff[1];

    // ----------------------------------------------------------------
    // APB slave: answer computed in setup, returned in access
    // ----------------------------------------------------------------
    assign slot = decodeSlot(paddr);
    assign setupPhase = psel & ~penable;
    // Write lands at the edge where access meets ready, never with an error
    assign writeTaken = psel & penable & pwrite & pready_ff & ~pslverr_ff;

    always_comb begin
        statusWord = '0;
        statusWord[EDGE_CNT_W-1:0] = refEdgeCnt_ff;
        statusWord[`DCRB_STAT_FLAGS_LO +: 5] = {refLevel, freqActive_ff, useRef_ff,
            pulseOutInt, pulseOeInt};
    end

    always_comb begin
        case (slot)
            3'h0, 3'h1, 3'h2, 3'h3: readWord = cfgWord_ff[slot[1:0]]; // see R13
            `DCRB_SLOT_STATUS: readWord = statusWord;
            default: readWord = '0;
        endcase
    end

    always_comb begin
        nxt_pready = setupPhase;
        nxt_pslverr = 1'b0;
        nxt_prdata = prdata_ff;
        if (setupPhase) begin
            // Unmapped address, or a write to the read-only status word
            nxt_pslverr = (slot == `DCRB_SLOT_NONE)
                || (pwrite && slot == `DCRB_SLOT_STATUS);
            nxt_prdata = pwrite ? prdata_ff : readWord;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    // ----------------------------------------------------------------
    // Configuration words
    // ----------------------------------------------------------------
    // Every byte enabled by pstrb is stored, parity and reserved bits included,
    // so a read returns each byte as software last wrote it.
    always_comb begin
        for (int w = 0; w < NUM_CFG; w++) begin
            nxt_cfgWord[w] = cfgWord_ff[w];
            if (writeTaken && slot == 3'(w)) begin
                for (int b = 0; b < 4; b++) begin
                    if (pstrb[b]) begin
                        nxt_cfgWord[w][b*8 +: 8] = pwdata[b*8 +: 8]; // see R13
                    end
                end
            end
        end
    end

    generate
        for (genvar g = 0; g < NUM_CFG; g++) begin : gen_cfg
            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    cfgWord_ff[g] <= resetWord(g); // see R9 see R10 see R13
                end else begin
                    cfgWord_ff[g] <= nxt_cfgWord[g];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Decoded device settings
    // ----------------------------------------------------------------
    always_comb begin
        // Ceiling is meaningless outside frequency mode, so it reads zero
        nxt_freqActive = (speedCommandSource == `DCRB_SRC_FREQ); // see R12
        nxt_freqCeiling = nxt_freqActive
            ? devCfg[`DCRB_MAXF_HI:`DCRB_MAXF_LO] : 15'h0000; // see R2 see R12
        nxt_ssmOn = ~devCfg[`DCRB_SSM_BIT]; // see R3
        nxt_sleepSel = devCfg[`DCRB_IDLE_BIT]; // see R4
        nxt_bandLow = devCfg[`DCRB_BAND_BIT]; // see R5
        // Reserved clock codes leave the internal oscillator in charge
        nxt_useRef = (devCfg[`DCRB_CLK_HI:`DCRB_CLK_LO] == `DCRB_CLK_EXT)
            && devCfg[`DCRB_EXTEN_BIT]; // see R6 see R7
        nxt_refKhz = `DCRB_RATE_BASE_KHZ
            << devCfg[`DCRB_RATE_HI:`DCRB_RATE_LO]; // see R8
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            freqActive_ff <= 1'b0;
            freqCeiling_ff <= 15'h0000;
            ssmOn_ff <= 1'b1;
            sleepSel_ff <= 1'b0;
            bandLow_ff <= 1'b0;
            useRef_ff <= 1'b0;
            refKhz_ff <= `DCRB_RATE_BASE_KHZ;
        end else begin
            freqActive_ff <= nxt_freqActive;
            freqCeiling_ff <= nxt_freqCeiling;
            ssmOn_ff <= nxt_ssmOn;
            sleepSel_ff <= nxt_sleepSel;
            bandLow_ff <= nxt_bandLow;
            useRef_ff <= nxt_useRef;
            refKhz_ff <= nxt_refKhz;
        end
    end

    // ----------------------------------------------------------------
    // Outside reference clock monitor
    // ----------------------------------------------------------------
    // Edges are counted only while the reference is selected, so the
    // count tells software whether the pin really carries a clock.
    dcrb_sync2 u_refSync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .pinIn(outsideRefPin),
        .levelOut(refLevel),
        .risePulse(refRise)
    );

    always_comb begin
        nxt_refTick = refRise & useRef_ff; // see R7
        nxt_refEdgeCnt = refEdgeCnt_ff;
        if (refRise && useRef_ff) begin
            nxt_refEdgeCnt = refEdgeCnt_ff + EDGE_CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            refTick_ff <= 1'b0;
            refEdgeCnt_ff <= '0;
        end else begin
            refTick_ff <= nxt_refTick;
            refEdgeCnt_ff <= nxt_refEdgeCnt;
        end
    end

    // ----------------------------------------------------------------
    // Speed-pulse output
    // ----------------------------------------------------------------
    dcrb_pulse_out u_pulse (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .faultActive(motorFault),
        .motorHalted(motorHalted),
        .pulseIn(rawSpeedPulse),
        .faultBehaviour(cfgWord_ff[0][`DCRB_FLT_HI:`DCRB_FLT_LO]), // see R1
        .pulseOut(pulseOutInt),
        .pulseOe(pulseOeInt)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign speedPulseOut = pulseOutInt;
    assign speedPulseOe = pulseOeInt;
    assign freqCeilingHz = freqCeiling_ff;
    assign freqCeilingActive = freqActive_ff;
    assign spreadSpectrumOn = ssmOn_ff;
    assign idleSleepSelect = sleepSel_ff;
    assign dutyInputBandLow = bandLow_ff;
    assign useOutsideReference = useRef_ff;
    assign outsideReferenceKhz = refKhz_ff;
    assign outsideReferenceTick = refTick_ff;
    assign gateDriverOneWord = cfgWord_ff[2];
    assign gateDriverTwoWord = cfgWord_ff[3];

endmodule

// File: tb/dcrb_regbank_asserts.sv
/*
 Port-level checker of the configuration register bank.
 Assumes bind onto dcrb_regbank; all ports on core_clk.
*/
`timescale 1ns/1ps
`include "dcrb_cfg.svh"
module dcrb_regbank_asserts import dcrb_pkg::*; #(
    parameter int ADDR_W = 12
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic motorFault,
    input wire logic rawSpeedPulse,
    input wire logic [1:0] speedCommandSource,
    input wire logic speedPulseOut,
    input wire logic speedPulseOe,
    input wire logic [14:0] freqCeilingHz,
    input wire logic freqCeilingActive,
    input wire logic spreadSpectrumOn,
    input wire logic idleSleepSelect,
    input wire logic dutyInputBandLow,
    input wire logic useOutsideReference,
    input wire logic [10:0] outsideReferenceKhz
);
    localparam logic [9:0] DEV_ADDR = {`DCRB_IDX_DEV_CFG, 2'h0};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // ------------------------
    // Sequences
    // ------------------------
    sequence s_setup;
        psel && !penable;
    endsequence
    // Full-word device word write
    sequence s_dev_wr;
        psel && penable && pready && pwrite && paddr == DEV_ADDR && pstrb == 4'hF;
    endsequence
    // ------------------------
    // Assertions
    // ------------------------
    a_ready_setup: assert property (s_setup |=> pready && psel && penable)
        else $error("pready missing after setup");
    a_ready_access: assert property (pready |-> psel && penable ##1 !pready)
        else $error("pready not single access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_spread_inv: assert property (s_dev_wr |->
        ##2 spreadSpectrumOn == !$past(pwdata[14], 2))
        else $error("spread polarity wrong");
    a_idle_sel: assert property (s_dev_wr |->
        ##2 idleSleepSelect == $past(pwdata[11], 2))
        else $error("idle select wrong");
    a_band_sel: assert property (s_dev_wr |->
        ##2 dutyInputBandLow == $past(pwdata[10], 2))
        else $error("duty band select wrong");
    a_ref_rate: assert property (s_dev_wr |->
        ##2 outsideReferenceKhz == (11'h008 << $past(pwdata[5:3], 2)))
        else $error("ref rate wrong");
    a_ref_enable: assert property (s_dev_wr |-> ##2 useOutsideReference ==
        ($past(pwdata[9:8], 2) == 2'h3 && $past(pwdata[6], 2)))
        else $error("ref enable wrong");
    a_ceil_follow: assert property ($past(arst_n) |->
        freqCeilingActive == ($past(speedCommandSource) == 2'h3))
        else $error("ceiling active wrong");
    a_ceil_zero: assert property (!freqCeilingActive |-> freqCeilingHz == 15'h0000)
        else $error("ceiling not zero");
    a_float_low: assert property (!speedPulseOe |-> !speedPulseOut && $past(motorFault))
        else $error("release without fault");
    a_pulse_normal: assert property ($past(arst_n) && !$past(motorFault) |->
        speedPulseOe && speedPulseOut == $past(rawSpeedPulse))
        else $error("pulse not following");
endmodule
bind dcrb_regbank dcrb_regbank_asserts #(.ADDR_W(ADDR_W)) u_chk (.core_clk(core_clk),
    .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .motorFault(motorFault), .rawSpeedPulse(rawSpeedPulse),
    .speedCommandSource(speedCommandSource), .speedPulseOut(speedPulseOut),
    .speedPulseOe(speedPulseOe), .freqCeilingHz(freqCeilingHz),
    .freqCeilingActive(freqCeilingActive), .spreadSpectrumOn(spreadSpectrumOn),
    .idleSleepSelect(idleSleepSelect), .dutyInputBandLow(dutyInputBandLow),
    .useOutsideReference(useOutsideReference), .outsideReferenceKhz(outsideReferenceKhz));

// File: tb/tb_top.sv
/*
 Self-checking testbench of the configuration register bank.
 Assumes zero-wait APB answers from the bank.
*/
`timescale 1ns/1ps
`include "dcrb_cfg.svh"
module tb_top import dcrb_pkg::*;;
    localparam logic [11:0] A_PIN = 12'({`DCRB_IDX_PIN_CFG_TWO, 2'h0});
    localparam logic [11:0] A_DEV = 12'({`DCRB_IDX_DEV_CFG, 2'h0});
    localparam logic [11:0] A_GD1 = 12'({`DCRB_IDX_GD_CFG_ONE, 2'h0});
    localparam logic [11:0] A_GD2 = 12'({`DCRB_IDX_GD_CFG_TWO, 2'h0});
    localparam logic [11:0] A_STAT = 12'({`DCRB_IDX_STATUS, 2'h0});
    logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, gd1, gd2, rdat;
    logic [3:0] pstrb;
    logic motorFault, motorHalted, rawSpeedPulse, outsideRefPin, errFlag;
    logic [1:0] speedCommandSource;
    logic speedPulseOut, speedPulseOe, ceilOn, spreadOn, idleSleep, bandLow, useRef, refTick;
    logic [14:0] ceilHz;
    logic [10:0] refKhz;
    int n_fail, check_count, tickCnt;

    dcrb_regbank uut (.core_clk(core_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .motorFault(motorFault),
        .motorHalted(motorHalted), .rawSpeedPulse(rawSpeedPulse),
        .speedCommandSource(speedCommandSource), .outsideRefPin(outsideRefPin),
        .speedPulseOut(speedPulseOut), .speedPulseOe(speedPulseOe), .freqCeilingHz(ceilHz),
        .freqCeilingActive(ceilOn), .spreadSpectrumOn(spreadOn), .idleSleepSelect(idleSleep),
        .dutyInputBandLow(bandLow), .useOutsideReference(useRef),
        .outsideReferenceKhz(refKhz), .outsideReferenceTick(refTick),
        .gateDriverOneWord(gd1), .gateDriverTwoWord(gd2));

    initial begin
        core_clk = 0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (refTick === 1'b1) tickCnt++;
    // ------------------------
    // Common tasks
    // ------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Holds the request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s);
        int k;
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge core_clk) penable <= 1;
        k = 0;
        do begin @(posedge core_clk); k++; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin n_fail++; print_verdict(); end
        rdat = prdata; errFlag = pslverr;
        psel <= 0; penable <= 0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0, 4'h0);
        chk(rdat, exp);
    endtask
    task automatic do_reset();
        arst_n <= 0;
        repeat (12) @(posedge core_clk);
        arst_n <= 1;
        @(posedge core_clk);
    endtask
    // ------------------------
    // Scenarios
    // ------------------------
    task automatic t_reset_vals();
        rd(A_PIN, 32'h0);
        rd(A_DEV, `DCRB_RST_DEV_CFG);
        rd(A_GD1, 32'h0022_8000);
        rd(A_GD2, 32'h0120_0000);
        chk({spreadOn, idleSleep, bandLow, useRef, refKhz}, {4'h8, 11'h008});
        chk(gd1, 32'h0022_8000);
        chk(gd2, 32'h0120_0000);
    endtask
    task automatic t_access();
        logic [11:0] regs [4];
        regs = '{A_PIN, A_DEV, A_GD1, A_GD2};
        apb(1, A_GD2, 32'hFFFF_FFFF, 4'h1);
        rd(A_GD2, 32'h0120_00FF);
        apb(0, 12'h004, 32'h0, 4'h0);
        chk(rdat, 32'h0);
        chk(errFlag, 1'b1);
        apb(1, A_STAT, 32'hFFFF_FFFF, 4'hF);
        chk(errFlag, 1'b1);
        foreach (regs[i]) begin
            apb(1, regs[i], 32'hFFFF_FFFF, 4'hF);
            rd(regs[i], 32'hFFFF_FFFF);
            apb(1, regs[i], 32'h8000_0000, 4'hF);
            rd(regs[i], 32'h8000_0000);
        end
        chk(gd1, 32'h8000_0000);
    endtask
    task automatic t_dev_fields();
        logic [2:0] c;
        for (int i = 0; i < 12; i++) begin
            c = 3'(i);
            if (i < 8) apb(1, A_DEV, {17'h0, c[0], 2'h0, c[1], c[2], 4'hD, c, 3'h0}, 4'hF);
            else apb(1, A_DEV, {22'h0, 2'(i - 8), 1'b0, i != 11, 6'h0}, 4'hF);
            @(posedge core_clk);
            if (i < 8) chk({spreadOn, idleSleep, bandLow, useRef, refKhz},
                {!c[0], c[1], c[2], 1'b1, 11'h008 << c});
            else chk(useRef, 1'b0);
        end
    endtask
    task automatic t_ceiling();
        apb(1, A_DEV, 32'h5A5A_0000, 4'hF);
        speedCommandSource <= 2'h3;
        repeat (2) @(posedge core_clk);
        chk({ceilOn, ceilHz}, {1'b1, 15'h5A5A});
        speedCommandSource <= 2'h1;
        repeat (2) @(posedge core_clk);
        chk({ceilOn, ceilHz}, 16'h0);
        speedCommandSource <= 2'h0;
    endtask
    task automatic step(input logic raw, input logic halt, input logic [1:0] exp);
        @(posedge core_clk) begin rawSpeedPulse <= raw; motorHalted <= halt; end
        repeat (2) @(posedge core_clk);
        chk({speedPulseOe, speedPulseOut}, exp);
    endtask
    task automatic t_fault();
        for (int c = 0; c < 4; c++) begin
            apb(1, A_PIN, 32'(c) << 11, 4'hF);
            motorFault <= 1;
            step(1, 0, (c == 1) ? 2'b00 : (c == 2) ? 2'b10 : 2'b11);
            step(0, 0, (c == 1) ? 2'b00 : 2'b10);
            step(1, 1, (c == 1) ? 2'b00 : 2'b10);
            @(posedge core_clk) motorFault <= 0;
            step(1, 0, 2'b11);
            step(0, 0, 2'b10);
        end
    endtask
    task automatic t_ref();
        apb(1, A_DEV, 32'h0000_0348, 4'hF);
        tickCnt = 0;
        repeat (4) begin
            @(posedge core_clk) outsideRefPin <= 1;
            repeat (6) @(posedge core_clk);
            outsideRefPin <= 0;
            repeat (6) @(posedge core_clk);
        end
        chk(tickCnt, 4);
        apb(0, A_STAT, 32'h0, 4'h0);
        chk(rdat[20:0], 21'h05_0004);
    endtask
    // ------------------------
    // Main sequence
    // ------------------------
    initial begin
        {arst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {motorFault, motorHalted, rawSpeedPulse, outsideRefPin, speedCommandSource} = '0;
        n_fail = 0; check_count = 0; tickCnt = 0;
        do_reset();
        t_reset_vals();
        t_access();
        t_dev_fields();
        t_ceiling();
        t_fault();
        t_ref();
        // Mid-run reset restores words
        do_reset();
        t_reset_vals();
        print_verdict();
    end
endmodule
